// file: rtl/tpc_flag.sv
// One event flag with its read-then-write-zero clearing sequence
`timescale 1ns/100ps
`default_nettype none
module tpc_flag import tpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_set,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic i_wbit,
  output logic o_flag
);

  typedef struct packed {
    logic flag;
    logic armed;
  } tpc_flag_s;

  tpc_flag_s s_q;
  tpc_flag_s s_d;

  always_comb begin
    s_d = s_q;
    if (i_set) begin
      s_d.flag = 1'b1;
      s_d.armed = 1'b0;
    end else if (i_write) begin
      if (s_q.armed && !i_wbit) begin
        s_d.flag = 1'b0;
      end
      s_d.armed = 1'b0;
    end else if (i_read && s_q.flag) begin
      s_d.armed = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_flag = s_q.flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_flag_set_wins: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_set |=> (o_flag && !s_q.armed))
    else $error("event did not leave the flag set and the sequence reset");
  a_flag_clear_seq: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.flag && s_q.armed && i_write && !i_wbit && !i_set) |=> !o_flag)
    else $error("armed zero write did not clear the flag");
  a_flag_no_blind: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.flag && !s_q.armed && !i_set) |=> o_flag)
    else $error("flag cleared without a prior read");
  a_flag_arm_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_read && s_q.flag && !i_set && !i_write) |=> (s_q.armed && o_flag))
    else $error("read of a set flag did not start the clearing sequence");

endmodule : tpc_flag
`default_nettype wire

// file: rtl/tpc_pkg.sv
// Shared constants and types of the timer PWM channel block
package tpc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCH = 2;
  localparam int AW = 8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_IRQ_EN = 8'h08;
  localparam logic [AW-1:0] OFS_COUNT = 8'h0C;
  localparam logic [AW-1:0] OFS_MODULO = 8'h10;
  localparam logic [AW-1:0] OFS_CH_BASE = 8'h14;
  localparam logic [AW-1:0] OFS_CH_STRIDE = 8'h08;
  localparam logic [AW-1:0] OFS_CH_VAL = 8'h04;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_PS_LSB = 0;
  localparam int CTRL_PS_MSB = 2;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_CPWM_BIT = 4;
  localparam int CHC_MSB = 2;
  localparam int CNT_DIR_BIT = 16;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CH_LSB = 1;

  // ----------------------------------------
  // Values after reset and fixed counts
  // ----------------------------------------
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_MODULO = 16'h0000;
  localparam logic [15:0] RST_CH_VAL = 16'h0000;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [6:0] DIV_STEP = 7'h01;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
  } tpc_apb_req_s;

  typedef struct packed {
    logic out_mode;
    logic edge_level_select_high;
    logic edge_level_select_low;
  } tpc_ch_cfg_s;

  typedef struct packed {
    logic center_align_select;
    logic run;
    logic [2:0] prescale;
  } tpc_ctrl_s;

endpackage : tpc_pkg

// file: rtl/tpc_sync.sv
// Two-stage synchroniser for the channel pin inputs
`timescale 1ns/100ps
`default_nettype none
module tpc_sync import tpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [NCH-1:0] i_async,
  output logic [NCH-1:0] o_sync
);

  typedef struct packed {
    logic [NCH-1:0] meta;
    logic [NCH-1:0] sync;
  } tpc_sync_s;

  tpc_sync_s s_q;
  tpc_sync_s s_d;

  always_comb begin
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.sync;

endmodule : tpc_sync
`default_nettype wire

// file: rtl/tpc_top.sv
// Timer PWM channels with center-aligned output and flag interrupts
// ----------------------------------------
// What this block does
// - Center-aligned mode with any channel select pair nonzero forces all channel pins out.
// - Center-aligned, select pair one-zero: clear on up-count match, set on down-count match.
// - The overflow flag sets when the counter leaves its terminal count.
// - A channel flag sets on every input capture or output compare event of that channel.
// - The interrupt request to the interrupt controller is active high.
// - Every flag can be polled through the status register with interrupts disabled.
// - The interrupt is a level, high while an enabled flag stays set.
// - A flag clears only when it is set at the access edge of a status read and software then writes zero to it.
// - An event between that read and the zero write keeps the flag set.
// - Outside center-aligned mode the overflow flag sets on the modulo to zero roll.
// - A free-running counter sets the overflow flag on the wrap from all ones to zero.
// ----------------------------------------
`timescale 1ns/100ps
`default_nettype none
module tpc_top import tpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire tpc_apb_req_s i_apb,
  input wire logic [NCH-1:0] i_ch_pin,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [NCH-1:0] o_ch_out,
  output logic [NCH-1:0] o_ch_oe,
  output logic o_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    tpc_ctrl_s ctrl;
    logic [NCH:0] irq_en;
    logic [15:0] cnt;
    logic count_down;
    logic [15:0] modulo;
    tpc_ch_cfg_s [NCH-1:0] ch_cfg;
    logic [NCH-1:0][15:0] ch_val;
    logic [6:0] div;
    logic [NCH-1:0] pin_prev;
    logic [NCH-1:0] ch_out;
    logic [NCH-1:0] ch_oe;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tpc_state_s;

  tpc_state_s s_q;
  tpc_state_s s_d;

  logic [NCH-1:0] sync_pin;
  logic [NCH:0] flags;
  logic [NCH:0] flag_set;
  logic [NCH-1:0] match;
  logic [NCH-1:0] ch_evt;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [15:0] term;
  logic [31:0] rdata;
  logic tick;
  logic ovf_evt;
  logic els_any;
  logic hit;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic stat_rd;
  logic stat_wr;
  logic irq_any;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic els_on(input tpc_ch_cfg_s cfg);
    return cfg.edge_level_select_high || cfg.edge_level_select_low;
  endfunction : els_on

  function automatic logic [AW-1:0] ch_addr(input int n, input logic is_val);
    logic [AW-1:0] base;
    base = OFS_CH_BASE + AW'(n) * OFS_CH_STRIDE;
    return is_val ? base + OFS_CH_VAL : base;
  endfunction : ch_addr

  function automatic logic tick_of(input logic [6:0] div, input logic [2:0] ps);
    logic [7:0] mask;
    mask = (8'h01 << ps) - 8'h01;
    return (div & mask[6:0]) == mask[6:0];
  endfunction : tick_of

  // ----------------------------------------
  // Bus phase decode
  // ----------------------------------------
  assign setup = i_apb.psel && !i_apb.penable;
  assign wr_acc = i_apb.psel && i_apb.penable && s_q.pready && i_apb.pwrite;
  assign rd_acc = i_apb.psel && i_apb.penable && s_q.pready && !i_apb.pwrite;
  assign stat_rd = rd_acc && (i_apb.paddr == OFS_STATUS);
  assign stat_wr = wr_acc && (i_apb.paddr == OFS_STATUS);
  assign flag_set = {ch_evt, ovf_evt};
  assign irq_any = |(flags & s_q.irq_en);

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  tpc_sync u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_ch_pin),
    .o_sync(sync_pin)
  );

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  for (genvar g = 0; g <= NCH; g++) begin : g_flag
    tpc_flag u_flag (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_set(flag_set[g]),
      .i_read(stat_rd),
      .i_write(stat_wr),
      .i_wbit(i_apb.pwdata[g]),
      .o_flag(flags[g])
    );
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    term = (s_q.modulo == RST_MODULO) ? CNT_ALL_ONES : s_q.modulo;
    tick = s_q.ctrl.run && tick_of(s_q.div, s_q.ctrl.prescale);
    ovf_evt = 1'b0;
    match = '0;
    ch_evt = '0;
    rise = '0;
    fall = '0;
    els_any = 1'b0;
    rdata = RST_DATA;
    hit = 1'b1;

    // Prescaler and counter
    if (s_q.ctrl.run) begin
      s_d.div = s_q.div + DIV_STEP;
    end
    if (tick) begin
      if (!s_q.ctrl.center_align_select) begin
        s_d.count_down = 1'b0;
        if (s_q.cnt == term) begin
          s_d.cnt = RST_CNT;
          ovf_evt = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + CNT_STEP;
        end
      end else if (!s_q.count_down) begin
        if (s_q.cnt >= term) begin
          s_d.count_down = 1'b1;
          s_d.cnt = s_q.cnt - CNT_STEP;
          ovf_evt = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + CNT_STEP;
        end
      end else begin
        if (s_q.cnt == RST_CNT) begin
          s_d.count_down = 1'b0;
          s_d.cnt = s_q.cnt + CNT_STEP;
        end else begin
          s_d.cnt = s_q.cnt - CNT_STEP;
        end
      end
    end

    // Channels
    for (int n = 0; n < NCH; n++) begin
      match[n] = tick && (s_q.cnt == s_q.ch_val[n]);
      rise[n] = sync_pin[n] && !s_q.pin_prev[n];
      fall[n] = !sync_pin[n] && s_q.pin_prev[n];
      s_d.pin_prev[n] = sync_pin[n];
      s_d.ch_oe[n] = s_q.ch_cfg[n].out_mode && els_on(s_q.ch_cfg[n]);
      if (els_on(s_q.ch_cfg[n])) begin
        els_any = 1'b1;
      end
      if (s_q.ctrl.center_align_select) begin
        if (match[n] && els_on(s_q.ch_cfg[n])) begin
          ch_evt[n] = 1'b1;
          s_d.ch_out[n] = s_q.count_down ^ s_q.ch_cfg[n].edge_level_select_low;
        end
      end else if (s_q.ch_cfg[n].out_mode) begin
        if (match[n]) begin
          ch_evt[n] = 1'b1;
          case ({s_q.ch_cfg[n].edge_level_select_high, s_q.ch_cfg[n].edge_level_select_low})
            2'b01: begin
              s_d.ch_out[n] = !s_q.ch_out[n];
            end
            2'b10: begin
              s_d.ch_out[n] = 1'b0;
            end
            2'b11: begin
              s_d.ch_out[n] = 1'b1;
            end
            default: begin
              s_d.ch_out[n] = s_q.ch_out[n];
            end
          endcase
        end
      end else begin
        if ((s_q.ch_cfg[n].edge_level_select_low && rise[n]) ||
            (s_q.ch_cfg[n].edge_level_select_high && fall[n])) begin
          ch_evt[n] = 1'b1;
          s_d.ch_val[n] = s_q.cnt;
        end
      end
    end
    if (s_q.ctrl.center_align_select && els_any) begin
      s_d.ch_oe = '1;
    end

    // Interrupt output
    s_d.irq = irq_any;

    // Register writes, taken at the access edge
    if (wr_acc) begin
      case (i_apb.paddr)
        OFS_CTRL: begin
          s_d.ctrl.prescale = i_apb.pwdata[CTRL_PS_MSB:CTRL_PS_LSB];
          s_d.ctrl.run = i_apb.pwdata[CTRL_RUN_BIT];
          s_d.ctrl.center_align_select = i_apb.pwdata[CTRL_CPWM_BIT];
        end
        OFS_IRQ_EN: begin
          s_d.irq_en = i_apb.pwdata[NCH:0];
        end
        OFS_COUNT: begin
          s_d.cnt = RST_CNT;
          s_d.div = '0;
          s_d.count_down = 1'b0;
        end
        OFS_MODULO: begin
          s_d.modulo = i_apb.pwdata[15:0];
        end
        default: begin
          for (int n = 0; n < NCH; n++) begin
            if (i_apb.paddr == ch_addr(n, 1'b0)) begin
              s_d.ch_cfg[n] = i_apb.pwdata[CHC_MSB:0];
            end
            if (i_apb.paddr == ch_addr(n, 1'b1)) begin
              s_d.ch_val[n] = i_apb.pwdata[15:0];
            end
          end
        end
      endcase
    end

    // Read data, prepared in the setup cycle
    case (i_apb.paddr)
      OFS_CTRL: begin
        rdata[CTRL_PS_MSB:CTRL_PS_LSB] = s_q.ctrl.prescale;
        rdata[CTRL_RUN_BIT] = s_q.ctrl.run;
        rdata[CTRL_CPWM_BIT] = s_q.ctrl.center_align_select;
      end
      OFS_STATUS: begin
        rdata[NCH:0] = flags;
      end
      OFS_IRQ_EN: begin
        rdata[NCH:0] = s_q.irq_en;
      end
      OFS_COUNT: begin
        rdata[15:0] = s_q.cnt;
        rdata[CNT_DIR_BIT] = s_q.count_down;
      end
      OFS_MODULO: begin
        rdata[15:0] = s_q.modulo;
      end
      default: begin
        hit = 1'b0;
        for (int n = 0; n < NCH; n++) begin
          if (i_apb.paddr == ch_addr(n, 1'b0)) begin
            hit = 1'b1;
            rdata[CHC_MSB:0] = s_q.ch_cfg[n];
          end
          if (i_apb.paddr == ch_addr(n, 1'b1)) begin
            hit = 1'b1;
            rdata[15:0] = s_q.ch_val[n];
          end
        end
      end
    endcase
    s_d.pready = setup;
    s_d.pslverr = setup && !hit;
    if (setup) begin
      s_d.prdata = (i_apb.pwrite || !hit) ? RST_DATA : rdata;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_ch_out = s_q.ch_out;
  assign o_ch_oe = s_q.ch_oe;
  assign o_irq = s_q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_cpwm_pins_out: assert property (
    (s_q.ctrl.center_align_select && els_any) |=> (o_ch_oe == '1))
    else $error("center-aligned mode did not force all channel pins out");
  a_up_match_clear: assert property (
    (s_q.ctrl.center_align_select && match[0] && !s_q.count_down &&
     s_q.ch_cfg[0].edge_level_select_high && !s_q.ch_cfg[0].edge_level_select_low)
    |=> !o_ch_out[0])
    else $error("up-count match did not clear the pin");
  a_down_match_set: assert property (
    (s_q.ctrl.center_align_select && match[0] && s_q.count_down &&
     s_q.ch_cfg[0].edge_level_select_high && !s_q.ch_cfg[0].edge_level_select_low)
    |=> o_ch_out[0])
    else $error("down-count match did not set the pin");
  a_inv_pwm_edges: assert property (
    (s_q.ctrl.center_align_select && match[1] && s_q.ch_cfg[1].edge_level_select_low)
    |=> (o_ch_out[1] == !$past(s_q.count_down)))
    else $error("inverted waveform edge has the wrong level");
  a_cpwm_overflow: assert property (
    (s_q.ctrl.center_align_select && tick && !s_q.count_down && s_q.cnt >= term)
    |=> (flags[STAT_OVF_BIT] && s_q.count_down))
    else $error("terminal count did not set the overflow flag");
  a_mod_wrap_flag: assert property (
    (!s_q.ctrl.center_align_select && tick && s_q.modulo != RST_MODULO &&
     s_q.cnt == s_q.modulo) |=> (flags[STAT_OVF_BIT] && s_q.cnt == RST_CNT))
    else $error("modulo roll did not set the overflow flag");
  a_free_wrap_flag: assert property (
    (!s_q.ctrl.center_align_select && tick && s_q.modulo == RST_MODULO &&
     s_q.cnt == CNT_ALL_ONES) |=> (flags[STAT_OVF_BIT] && s_q.cnt == RST_CNT))
    else $error("all-ones wrap did not set the overflow flag");
  a_ch_event_flag: assert property (
    ch_evt[0] |=> flags[STAT_CH_LSB])
    else $error("channel event did not set its flag");
  a_irq_level: assert property (
    irq_any |=> o_irq)
    else $error("enabled set flag gave no interrupt");
  a_irq_quiet: assert property (
    !irq_any |=> !o_irq)
    else $error("interrupt high with no enabled flag");
  a_status_poll: assert property (
    (setup && !i_apb.pwrite && i_apb.paddr == OFS_STATUS)
    |=> (o_prdata[NCH:0] == $past(flags) && o_pready))
    else $error("status read does not show the flags");

endmodule : tpc_top
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench of the timer PWM channel block
`timescale 1ns/100ps
`default_nettype none
module tb_top import tpc_pkg::*; ;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  tpc_apb_req_s apb = '0;
  logic [NCH-1:0] tb_pin = '0;
  logic [NCH-1:0] pin_w;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NCH-1:0] ch_out;
  logic [NCH-1:0] ch_oe;
  logic irq;
  logic taken;
  logic [31:0] rdat;
  logic rerr;
  int n_errors = 0;
  int samples_checked = 0;

  always #50 clk = ~clk;
  // Pin wire seen by the block: its own drive while enabled
  assign pin_w = (ch_oe & ch_out) | (~ch_oe & tb_pin);

  tpc_top DUT (
    .i_clk(clk), .i_nrst(nrst), .i_apb(apb), .i_ch_pin(pin_w), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_ch_out(ch_out), .o_ch_oe(ch_oe), .o_irq(irq)
  );
  tpc_irq_ctl u_ctl (.i_clk(clk), .i_nrst(nrst), .i_irq(irq), .o_taken(taken));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic fail_out(input string what);
    n_errors++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    conclude();
  endtask : fail_out

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb_xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_out("apb ready");
    // Answer taken at the access edge, then the request is released
    rdat = prdata;
    rerr = pslverr;
    apb <= '0;
  endtask : apb_xfer

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    apb_xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic clr_flags();
    rd(OFS_STATUS);
    wr(OFS_STATUS, 32'h0000_0000);
  endtask : clr_flags

  task automatic wait_taken(input int limit, output int n);
    n = 0;
    while (taken !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > limit) fail_out("irq wait");
    end
  endtask : wait_taken

  task automatic wait_cnt(input logic dn, input int lo, input int hi);
    int k;
    for (k = 0; k < 3000; k++) begin
      rd(OFS_COUNT);
      if (rdat[CNT_DIR_BIT] === dn && int'(rdat[15:0]) >= lo && int'(rdat[15:0]) <= hi) break;
    end
    if (k >= 3000) fail_out("count wait");
  endtask : wait_cnt

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(OFS_STATUS);
    check("status after reset", 32'h0000_0000, rdat);
    rd(8'h40);
    check("unmapped error", 32'h0000_0001, {31'h0, rerr});
    wr(OFS_IRQ_EN, 32'h0000_0007);
    rd(OFS_IRQ_EN);
    check("irq enable readback", 32'h0000_0007, rdat);
    wr(OFS_IRQ_EN, 32'h0000_0001);
    $display("test regs done");
  endtask : t_regs

  task automatic t_wrap();
    int n;
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0008);
    wait_taken(70000, n);
    check("free wrap delay", 32'h1, {31'h0, n >= 65536 && n <= 65542});
    wr(OFS_CTRL, 32'h0000_0000);
    clr_flags();
    wr(OFS_MODULO, 32'h0000_0003);
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0008);
    wait_taken(50, n);
    check("modulo wrap delay", 32'h1, {31'h0, n >= 4 && n <= 10});
    $display("test wrap done");
  endtask : t_wrap

  task automatic t_clear();
    int n;
    wr(OFS_CTRL, 32'h0000_0000);
    clr_flags();
    repeat (3) @(negedge clk);
    check("irq after clear", 32'h0, {31'h0, irq});
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_000F);
    wait_taken(600, n);
    check("irq level high", 32'h1, {31'h0, irq});
    rd(OFS_STATUS);
    check("flag polled", 32'h1, {31'h0, rdat[STAT_OVF_BIT]});
    wr(OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS);
    check("write one keeps flag", 32'h1, {31'h0, rdat[STAT_OVF_BIT]});
    // One overflow period is 512 clocks, so a new event lands here
    repeat (600) @(posedge clk);
    wr(OFS_STATUS, 32'h0000_0000);
    rd(OFS_STATUS);
    check("event after read", 32'h1, {31'h0, rdat[STAT_OVF_BIT]});
    wr(OFS_STATUS, 32'h0000_0000);
    repeat (3) @(negedge clk);
    check("irq after sequence", 32'h0, {31'h0, irq});
    wait_taken(600, n);
    wr(OFS_IRQ_EN, 32'h0000_0000);
    repeat (3) @(negedge clk);
    check("irq masked", 32'h0, {31'h0, irq});
    rd(OFS_STATUS);
    check("masked flag polled", 32'h1, {31'h0, rdat[STAT_OVF_BIT]});
    wr(OFS_CTRL, 32'h0000_0000);
    $display("test clear done");
  endtask : t_clear

  task automatic t_center();
    wr(OFS_MODULO, 32'h0000_0008);
    wr(OFS_CH_BASE, 32'h0000_0002);
    wr(OFS_CH_BASE + OFS_CH_VAL, 32'h0000_0003);
    wr(OFS_CH_BASE + OFS_CH_STRIDE, 32'h0000_0001);
    wr(OFS_CH_BASE + OFS_CH_STRIDE + OFS_CH_VAL, 32'h0000_0003);
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_001F);
    repeat (2) @(negedge clk);
    check("center enables", 32'h3, {30'h0, ch_oe});
    wait_cnt(1'b1, 1, 2);
    check("pins after down match", 32'h1, {30'h0, ch_out});
    wait_cnt(1'b0, 4, 7);
    check("pins after up match", 32'h2, {30'h0, ch_out});
    wr(OFS_CH_BASE + OFS_CH_STRIDE, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check("one pair forces all", 32'h3, {30'h0, ch_oe});
    wr(OFS_CTRL, 32'h0000_0000);
    $display("test center done");
  endtask : t_center

  task automatic t_event();
    int n;
    wr(OFS_CH_BASE, 32'h0000_0001);
    wr(OFS_CH_BASE + OFS_CH_STRIDE, 32'h0000_0005);
    wr(OFS_CH_BASE + OFS_CH_STRIDE + OFS_CH_VAL, 32'h0000_0002);
    clr_flags();
    wr(OFS_IRQ_EN, 32'h0000_0002);
    wr(OFS_COUNT, 32'h0000_0000);
    repeat (2) @(negedge clk);
    check("edge mode enables", 32'h2, {30'h0, ch_oe});
    wr(OFS_CTRL, 32'h0000_0008);
    @(posedge clk);
    tb_pin <= 2'b01;
    wait_taken(50, n);
    rd(OFS_STATUS);
    check("channel flags", 32'h6, {29'h0, rdat[2:0] & 3'b110});
    $display("test event done");
  endtask : t_event

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_wrap();
    t_clear();
    t_center();
    t_event();
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// file: verification/tpc_irq_ctl.sv
// Interrupt controller model that recognises the level request
`timescale 1ns/100ps
`default_nettype none
module tpc_irq_ctl (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_irq,
  output logic o_taken
);
  // ----------------------------------------
  // Request sampling
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_taken <= 1'b0;
    end else begin
      o_taken <= (i_irq === 1'b1);
    end
  end
endmodule : tpc_irq_ctl
`default_nettype wire
